// File: rtl/usart_irq_defs.vh
`ifndef USART_IRQ_DEFS_VH
`define USART_IRQ_DEFS_VH
// register byte offsets (printed offsets not all multiples of 4: index * 4)
`define IDX_ENABLE_CLEAR 8'h14
`define IDX_ENABLE_SET 8'h16
`define IDX_FLAGS 8'h18
`define IDX_STATUS 8'h1A
`define IDX_CONTROL 8'h20
`define ADDR_ENABLE_CLEAR 10'h050
`define ADDR_ENABLE_SET 10'h058
`define ADDR_FLAGS 10'h060
`define ADDR_STATUS 10'h068
`define ADDR_CONTROL 10'h080
// flag and enable layout
`define BIT_DATA_EMPTY 0
`define BIT_TRANSMIT_COMPLETE 1
`define BIT_RECEIVE_COMPLETE 2
`define BIT_RECEIVE_START 3
`define BIT_CTS_CHANGE 4
`define BIT_RECEIVE_BREAK 5
`define BIT_ERROR 7
`define FLAG_MASK 8'hBF
// status layout
`define ST_PARITY 0
`define ST_FRAMING 1
`define ST_OVERFLOW 2
`define ST_CTS 3
`define ST_SYNC 4
`define ST_COLLISION 5
`define STATUS_W1C_MASK 16'h0037
// control register layout
`define CTL_RX_ENABLE 0
`define CTL_START_FRAME_DETECT_ENABLE 1
`define CTL_COLLISION_DETECT_ENABLE 2
`define CTL_FLOW 3
`define CTL_FORM_LSB 4
`define CTL_FORM_MSB 7
`define CTL_MASK 8'hFF
// frame formats
`define FORM_PARITY 4'h1
`define FORM_AUTOBAUD 4'h4
`define FORM_AUTOBAUD_PARITY 4'h5
`define SYNC_VALUE 8'h55
`define RESET_ZERO8 8'h00
`define RESET_ZERO16 16'h0000
`endif

// File: rtl/usart_irq_status_logic.v
// Behaviour
// R1 - enable-set write one sets enable
// R2 - enable-clear write one clears enable
// R3 - both views share one enable set
// R4 - fixed bit layout, bit 6 zero
// R5 - any status error sets error flag
// R6 - break in auto-baud sets break flag
// R7 - cts level change sets change flag
// R8 - start with detection enabled sets flag
// R9 - receive complete follows unread data
// R10 - transmit complete after frame, no data
// R11 - data empty follows transmit buffer empty
// R12 - collision sets when detection enabled
// R13 - bad sync field in auto-baud
// R14 - cts bit shows pin when flow enabled
// R15 - overflow on start while buffer full
// R16 - framing error on zero stop bit
// R17 - errors belong to next unread character
// R18 - parity error when parity checking enabled
// R19 - irq high on enabled set flag
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ns
`include "usart_irq_defs.vh"
module usart_irq_status_logic (
  input wire clk,
  input wire rst,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg irq,
  input wire cts_pin,
  input wire rx_start_seen,
  input wire rx_char_done,
  input wire rx_stop_bit,
  input wire rx_parity_bad,
  input wire rx_break_seen,
  input wire [7:0] rx_sync_value,
  input wire rx_sync_done,
  input wire rx_buffer_full,
  input wire rx_shift_pending,
  input wire rx_data_read,
  input wire rx_unread,
  input wire tx_collision,
  input wire tx_shift_done,
  input wire tx_data_written,
  input wire tx_data_empty,
  output reg rx_enable,
  output reg start_frame_detect_enable,
  output reg collision_detect_enable,
  output reg flow_control_enable,
  output reg [3:0] frame_format
);

  reg [7:0] enable_reg;
  reg [7:0] flags_reg;
  reg [15:0] status_reg;
  reg [7:0] control_reg;
  reg [2:0] cts_sync_reg;
  reg cts_stable_reg;
  reg access_done_reg;
  reg [7:0] enable_next;
  reg [7:0] flags_next;
  reg [15:0] status_next;
  reg [7:0] control_next;
  reg [31:0] rdata_next;
  reg [7:0] err_set;
  wire req;
  wire take;
  wire wr;
  wire [7:0] wbyte0;
  wire [15:0] whalf;
  wire [15:0] wmask;
  wire form_autobaud;
  wire form_parity;
  wire cts_changed;
  wire rx_off;

  assign req = avs_read | avs_write;
  // one wait cycle: answer on the second edge of each request
  assign take = req & access_done_reg == 1'b0;
  // a write lands only at the edge where the master sees waitrequest low
  assign wr = avs_write & ~avs_waitrequest;
  assign wbyte0 = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign whalf = avs_writedata[15:0] & wmask;
  assign form_autobaud = control_reg[`CTL_FORM_MSB:`CTL_FORM_LSB] == `FORM_AUTOBAUD ||
                         control_reg[`CTL_FORM_MSB:`CTL_FORM_LSB] == `FORM_AUTOBAUD_PARITY;
  assign form_parity = control_reg[`CTL_FORM_MSB:`CTL_FORM_LSB] == `FORM_PARITY ||
                       control_reg[`CTL_FORM_MSB:`CTL_FORM_LSB] == `FORM_AUTOBAUD_PARITY;
  // stages two and three must agree, and stage three must differ from the stable level
  assign cts_changed = (cts_sync_reg[1] == cts_sync_reg[2]) && (cts_sync_reg[2] != cts_stable_reg);
  assign rx_off = ~control_reg[`CTL_RX_ENABLE];

  always @* begin
    control_next = control_reg;
    if (wr && avs_address == `ADDR_CONTROL) begin
      control_next = wbyte0 & `CTL_MASK;
    end
  end

  always @* begin
    enable_next = enable_reg;
    if (wr && avs_address == `ADDR_ENABLE_SET) begin
      enable_next = enable_reg | (wbyte0 & `FLAG_MASK); // R1 R3 R4
    end
    if (wr && avs_address == `ADDR_ENABLE_CLEAR) begin
      enable_next = enable_reg & ~(wbyte0 & `FLAG_MASK); // R2 R3
    end
  end

  always @* begin
    err_set = `RESET_ZERO8;
    status_next = status_reg;
    // write one clears; receiver disable clears all five error bits, collision included
    if (wr && avs_address == `ADDR_STATUS) begin
      status_next = status_next & ~(whalf & `STATUS_W1C_MASK);
    end
    if (rx_off) begin
      status_next = status_next & ~`STATUS_W1C_MASK; // R12 R13 R15 R16 R18
    end
    // hardware set wins over the write-one clear; only collision also sets while the receiver is disabled
    if (control_reg[`CTL_COLLISION_DETECT_ENABLE] && tx_collision) begin
      status_next[`ST_COLLISION] = 1'b1; // R12
      err_set[0] = 1'b1;
    end
    if (form_autobaud && rx_sync_done && rx_sync_value != `SYNC_VALUE && !rx_off) begin
      status_next[`ST_SYNC] = 1'b1; // R13
      err_set[1] = 1'b1;
    end
    if (rx_start_seen && rx_buffer_full && rx_shift_pending && !rx_off) begin
      status_next[`ST_OVERFLOW] = 1'b1; // R15
      err_set[2] = 1'b1;
    end
    // errors latch as the character lands and stand until read and cleared
    if (rx_char_done && !rx_stop_bit && !rx_off) begin
      status_next[`ST_FRAMING] = 1'b1; // R16 R17
      err_set[3] = 1'b1;
    end
    if (rx_char_done && form_parity && rx_parity_bad && !rx_off) begin
      status_next[`ST_PARITY] = 1'b1; // R18 R17
      err_set[4] = 1'b1;
    end
    status_next[`ST_CTS] = control_reg[`CTL_FLOW] & cts_stable_reg; // R14
    status_next[15:6] = 10'h000;
  end

  always @* begin
    flags_next = flags_reg;
    if (wr && avs_address == `ADDR_FLAGS) begin
      flags_next[`BIT_ERROR] = flags_reg[`BIT_ERROR] & ~wbyte0[`BIT_ERROR];
      flags_next[`BIT_RECEIVE_BREAK] = flags_reg[`BIT_RECEIVE_BREAK] & ~wbyte0[`BIT_RECEIVE_BREAK]; // R6
      flags_next[`BIT_CTS_CHANGE] = flags_reg[`BIT_CTS_CHANGE] & ~wbyte0[`BIT_CTS_CHANGE]; // R7
      flags_next[`BIT_RECEIVE_START] = flags_reg[`BIT_RECEIVE_START] & ~wbyte0[`BIT_RECEIVE_START]; // R8
      flags_next[`BIT_TRANSMIT_COMPLETE] = flags_reg[`BIT_TRANSMIT_COMPLETE] &
                                           ~wbyte0[`BIT_TRANSMIT_COMPLETE]; // R10
    end
    if (tx_data_written) begin
      flags_next[`BIT_TRANSMIT_COMPLETE] = 1'b0; // R10
    end
    if (|err_set) begin
      flags_next[`BIT_ERROR] = 1'b1; // R5
    end
    if (form_autobaud && rx_break_seen) begin
      flags_next[`BIT_RECEIVE_BREAK] = 1'b1; // R6
    end
    if (cts_changed) begin
      flags_next[`BIT_CTS_CHANGE] = 1'b1; // R7
    end
    if (control_reg[`CTL_START_FRAME_DETECT_ENABLE] && rx_start_seen) begin
      flags_next[`BIT_RECEIVE_START] = 1'b1; // R8
    end
    if (tx_shift_done && tx_data_empty && !tx_data_written) begin
      flags_next[`BIT_TRANSMIT_COMPLETE] = 1'b1; // R10
    end
    // data read or receiver disable drop it; writes never touch it
    flags_next[`BIT_RECEIVE_COMPLETE] = rx_unread & ~rx_data_read & ~rx_off; // R9
    flags_next[`BIT_DATA_EMPTY] = tx_data_empty & ~tx_data_written; // R11
    flags_next[6] = 1'b0; // R4
  end

  always @* begin
    rdata_next = 32'h00000000;
    case (avs_address)
      `ADDR_ENABLE_SET: begin
        rdata_next[7:0] = enable_reg; // R3
      end
      `ADDR_ENABLE_CLEAR: begin
        rdata_next[7:0] = enable_reg; // R3
      end
      `ADDR_FLAGS: begin
        rdata_next[7:0] = flags_reg;
      end
      `ADDR_STATUS: begin
        rdata_next[15:0] = status_reg; // R17
      end
      `ADDR_CONTROL: begin
        rdata_next[7:0] = control_reg;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_reg <= `RESET_ZERO8;
      flags_reg <= `RESET_ZERO8;
      status_reg <= `RESET_ZERO16;
      control_reg <= `RESET_ZERO8;
      cts_sync_reg <= 3'b000;
      cts_stable_reg <= 1'b0;
      access_done_reg <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
      rx_enable <= 1'b0;
      start_frame_detect_enable <= 1'b0;
      collision_detect_enable <= 1'b0;
      flow_control_enable <= 1'b0;
      frame_format <= 4'h0;
    end else begin
      enable_reg <= enable_next;
      flags_reg <= flags_next;
      status_reg <= status_next;
      control_reg <= control_next;
      cts_sync_reg <= {cts_sync_reg[1:0], cts_pin};
      if (cts_sync_reg[1] == cts_sync_reg[2]) begin
        cts_stable_reg <= cts_sync_reg[2];
      end
      access_done_reg <= take;
      avs_waitrequest <= ~take;
      if (take) begin
        avs_readdata <= rdata_next;
      end
      irq <= |(flags_next & enable_next & `FLAG_MASK); // R19
      rx_enable <= control_next[`CTL_RX_ENABLE];
      start_frame_detect_enable <= control_next[`CTL_START_FRAME_DETECT_ENABLE];
      collision_detect_enable <= control_next[`CTL_COLLISION_DETECT_ENABLE];
      flow_control_enable <= control_next[`CTL_FLOW];
      frame_format <= control_next[`CTL_FORM_MSB:`CTL_FORM_LSB];
    end
  end

endmodule

// File: verif/usart_irq_checker.sv
`timescale 1ns/1ns
`include "usart_irq_defs.vh"
module usart_irq_checker (
  input logic clk,
  input logic rst,
  input logic [9:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic irq,
  input logic cts_pin,
  input logic flow_control_enable,
  input logic rx_enable,
  input logic [3:0] frame_format
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire byte_reg = avs_address == `ADDR_ENABLE_CLEAR || avs_address == `ADDR_ENABLE_SET || avs_address == `ADDR_FLAGS;
  wire mapped = byte_reg || avs_address == `ADDR_STATUS || avs_address == `ADDR_CONTROL;
  sequence rd_done; avs_read && !avs_waitrequest; endsequence
  sequence wr_done; avs_write && !avs_waitrequest; endsequence
  // pin must sit still long enough to pass the synchroniser
  sequence cts_quiet; (flow_control_enable && $stable(cts_pin))[*6]; endsequence
  a_wait_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_unmapped_zero: assert property (rd_done ##0 !mapped |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_bit6_zero: assert property (rd_done ##0 byte_reg |-> avs_readdata[6] == 1'b0)
    else $error("reserved bit 6 reads one");
  a_status_upper: assert property (rd_done ##0 avs_address == `ADDR_STATUS |-> avs_readdata[15:6] == 10'h000)
    else $error("status upper bits not zero");
  a_mask_all: assert property (wr_done ##0 (avs_address == `ADDR_ENABLE_CLEAR && avs_writedata[7:0] == 8'hFF)
    |-> ##2 !irq)
    else $error("irq high with all enables cleared");
  a_ctl_copy: assert property (wr_done ##0 avs_address == `ADDR_CONTROL
    |=> rx_enable == $past(avs_writedata[0]) && frame_format == $past(avs_writedata[7:4]))
    else $error("control copy wrong");
  a_cts_level: assert property (cts_quiet ##0 rd_done ##0 avs_address == `ADDR_STATUS
    |-> avs_readdata[3] == cts_pin)
    else $error("cts status differs from pin");
endmodule
bind usart_irq_status_logic usart_irq_checker i_chk (.clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .cts_pin, .flow_control_enable, .rx_enable,
  .frame_format);

// File: verif/serial_node_model.sv
`timescale 1ns/1ns
module serial_node_model (
  input wire clk,
  input wire rst,
  input wire go,
  input wire [3:0] ev,
  output reg cts_pin,
  output reg rx_start_seen,
  output reg rx_char_done,
  output reg rx_stop_bit,
  output reg rx_parity_bad,
  output reg rx_break_seen,
  output reg [7:0] rx_sync_value,
  output reg rx_sync_done,
  output reg rx_buffer_full,
  output reg rx_shift_pending,
  output reg rx_data_read,
  output reg rx_unread,
  output reg tx_collision,
  output reg tx_shift_done,
  output reg tx_data_written,
  output reg tx_data_empty
);
  wire [15:0] hit = go ? (16'h0001 << ev) : 16'h0000;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {cts_pin, rx_start_seen, rx_char_done, rx_parity_bad, rx_break_seen, rx_sync_done} <= 6'h00;
      {rx_buffer_full, rx_shift_pending, rx_data_read, rx_unread} <= 4'h0;
      {tx_collision, tx_shift_done, tx_data_written} <= 3'h0;
      rx_sync_value <= 8'h00;
      rx_stop_bit <= 1'b1;
      tx_data_empty <= 1'b1;
    end else begin
      rx_start_seen <= hit[1] | hit[7];
      rx_char_done <= hit[2] | hit[3];
      rx_stop_bit <= !hit[2];
      rx_parity_bad <= hit[3];
      rx_break_seen <= hit[4];
      rx_sync_done <= hit[5] | hit[6];
      rx_sync_value <= hit[6] ? 8'h55 : 8'h12;
      rx_buffer_full <= hit[7];
      rx_shift_pending <= hit[7];
      tx_collision <= hit[8];
      tx_shift_done <= hit[9];
      if (hit[10]) cts_pin <= !cts_pin;
      rx_unread <= hit[11] | (rx_unread & !hit[12]);
      rx_data_read <= hit[12];
      tx_data_written <= hit[13];
      tx_data_empty <= hit[9] | (tx_data_empty & !hit[13]);
    end
  end
endmodule

// File: verif/usart_irq_status_logic_bench.sv
`timescale 1ns/1ns
`include "usart_irq_defs.vh"
module usart_irq_status_logic_bench;
  logic clk, avs_waitrequest, irq, cts_pin, rx_start_seen, rx_char_done, rx_stop_bit, rx_parity_bad;
  logic rx_break_seen, rx_sync_done, rx_buffer_full, rx_shift_pending, rx_data_read, rx_unread;
  logic tx_collision, tx_shift_done, tx_data_written, tx_data_empty, rx_enable;
  logic start_frame_detect_enable, collision_detect_enable, flow_control_enable;
  logic rst = 1'b1, go = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF, ev = 4'h0, frame_format;
  logic [7:0] rx_sync_value;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [27:0] r;
  int fails, compares;
  // event, control, flags, status
  logic [27:0] rows [15] = '{28'h1030900, 28'h1010100, 28'h2018102, 28'h3118101, 28'h3518101,
    28'h3010100, 28'h4412100, 28'h4010100, 28'h5418110, 28'h6410100, 28'h8058120, 28'h8010100,
    28'h7018104, 28'h9010300, 28'hA091108};
  usart_irq_status_logic i_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .cts_pin, .rx_start_seen, .rx_char_done,
    .rx_stop_bit, .rx_parity_bad, .rx_break_seen, .rx_sync_value, .rx_sync_done, .rx_buffer_full,
    .rx_shift_pending, .rx_data_read, .rx_unread, .tx_collision, .tx_shift_done, .tx_data_written,
    .tx_data_empty, .rx_enable, .start_frame_detect_enable, .collision_detect_enable,
    .flow_control_enable, .frame_format);
  serial_node_model i_node (.clk, .rst, .go, .ev, .cts_pin, .rx_start_seen, .rx_char_done, .rx_stop_bit,
    .rx_parity_bad, .rx_break_seen, .rx_sync_value, .rx_sync_done, .rx_buffer_full, .rx_shift_pending,
    .rx_data_read, .rx_unread, .tx_collision, .tx_shift_done, .tx_data_written, .tx_data_empty);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task end_sim;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t read %h want %h", $time, got, exp);
    end
  endtask
  task chk_irq(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t irq %b want %b", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    // look between edges: the value seen here is what the next rising edge samples
    do @(negedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task send(input logic [3:0] e);
    @(posedge clk);
    go <= 1'b1;
    ev <= e;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      r = rows[i];
      bus(1'b1, `ADDR_CONTROL, {24'h0, r[23:16]});
      bus(1'b1, `ADDR_ENABLE_SET, 32'hBE);
      send(r[27:24]);
      bus(1'b0, `ADDR_ENABLE_SET, 32'h0);
      chk(q, 32'hBE);
      bus(1'b0, `ADDR_ENABLE_CLEAR, 32'h0);
      chk(q, 32'hBE);
      bus(1'b0, `ADDR_STATUS, 32'h0);
      chk(q, {24'h0, r[7:0]});
      bus(1'b0, `ADDR_FLAGS, 32'h0);
      chk(q, {24'h0, r[15:8]});
      chk_irq(irq, |(r[15:8] & 8'hBE));
      bus(1'b1, `ADDR_STATUS, 32'h37);
      bus(1'b1, `ADDR_FLAGS, 32'hFF);
      bus(1'b1, `ADDR_ENABLE_CLEAR, 32'hFF);
    end
    send(4'h9);
    bus(1'b1, `ADDR_FLAGS, 32'h01);
    bus(1'b0, `ADDR_FLAGS, 32'h0);
    chk(q, 32'h03);
    send(4'hD);
    bus(1'b0, `ADDR_FLAGS, 32'h0);
    chk(q, 32'h00);
    send(4'hB);
    bus(1'b1, `ADDR_FLAGS, 32'h04);
    bus(1'b0, `ADDR_FLAGS, 32'h0);
    chk(q, 32'h04);
    send(4'hC);
    bus(1'b0, `ADDR_FLAGS, 32'h0);
    chk(q, 32'h00);
    send(4'h2);
    bus(1'b1, `ADDR_CONTROL, 32'h0);
    bus(1'b0, `ADDR_STATUS, 32'h0);
    chk(q, 32'h00);
    bus(1'b1, 10'h3FC, 32'hFF);
    bus(1'b0, 10'h3FC, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `ADDR_ENABLE_SET, 32'hFF);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, `ADDR_ENABLE_SET, 32'h0);
    chk(q, 32'h00);
    chk_irq(irq, 1'b0);
    end_sim;
  end
  initial begin
    #400000;
    fails++;
    $display("BAD %0t timeout", $time);
    end_sim;
  end
endmodule
